// [verilog/adc_acq_ctrl.sv]
`timescale 1ns/100ps
module adc_acq_ctrl
  import adc_acq_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  input  wire logic        RC_OSC,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic             SAMPLE,
  output logic             CONVERTING,
  output logic             BIT_STROBE,
  output logic             CONV_DONE
);

  // bus slave state
  logic                 wr_pending;
  logic                 next_wr_pending;
  logic [ADDR_BITS-1:0] wr_addr;
  logic [ADDR_BITS-1:0] next_wr_addr;
  logic [31:0]          next_hrdata;
  logic                 addr_phase;

  // register state
  logic [CFG_W-1:0]     config_reg;
  logic [CFG_W-1:0]     next_config_reg;
  logic                 go;
  logic                 next_go;

  // sequencer state
  state_type            state;
  state_type            next_state;
  logic [3:0]           periods;
  logic [3:0]           next_periods;
  logic                 next_sample;
  logic                 next_converting;
  logic                 next_bit_strobe;
  logic                 next_conv_done;

  // rc oscillator synchroniser
  logic                 rc_meta;
  logic                 rc_sync;
  logic                 rc_last;
  logic                 rc_rise;

  logic                 tick;
  logic                 run;
  logic                 go_write;
  logic                 start;
  logic                 finish;
  logic [ACQ_W-1:0]     acq_time;
  logic [CLK_W-1:0]     clk_sel;

  assign acq_time = config_reg[ACQ_MSB:ACQ_LSB];
  assign clk_sel  = config_reg[CLK_MSB:CLK_LSB];
  assign rc_rise  = rc_sync & ~rc_last;
  assign run      = (state != ST_IDLE);

  bit_period_gen u_bit_period_gen (
    .clk     (CLK_SYS),
    .rst     (RST),
    .run     (run),
    .select  (clk_sel),
    .rc_rise (rc_rise),
    .tick    (tick)
  );

  // zero-wait slave: writes land one cycle after their address phase
  assign addr_phase = HSEL & HREADY & (HTRANS == HTRANS_NONSEQ);

  always_comb begin
    next_wr_pending = addr_phase & HWRITE;
    next_wr_addr    = addr_phase ? HADDR[ADDR_BITS-1:0] : wr_addr;
  end

  assign go_write = wr_pending & (wr_addr == CONTROL_OFFSET)
                  & HWDATA[GO_BIT];
  assign finish   = (state == ST_CONVERT) & tick
                  & (periods == CONV_PERIODS - 4'h1);
  // a go written in the completing cycle is kept, not lost
  assign start    = go_write & (~go | finish);

  always_comb begin
    next_config_reg = config_reg;
    if (wr_pending && wr_addr == CONFIG_OFFSET) begin
      next_config_reg = HWDATA[CFG_W-1:0];
    end
    next_go = go;
    if (start) begin
      next_go = 1'b1;
    end else if (finish) begin
      next_go = 1'b0;
    end
  end

  // read data comes from next values so a read right after a write
  // sees the new contents; only the go bit shows progress
  always_comb begin
    next_hrdata = HRDATA;
    if (addr_phase && !HWRITE) begin
      case (HADDR[ADDR_BITS-1:0])
        CONFIG_OFFSET:  next_hrdata = {25'h0000000, next_config_reg};
        CONTROL_OFFSET: next_hrdata = {31'h00000000, next_go};
        default:        next_hrdata = 32'h00000000;
      endcase
    end
  end

  always_comb begin
    next_state      = state;
    next_periods    = periods;
    next_bit_strobe = 1'b0;
    next_conv_done  = 1'b0;
    case (state)
      ST_IDLE: begin
        next_periods = '0;
        if (start) begin
          if (acq_time == '0) begin
            next_state = ST_CONVERT;
          end else begin
            next_state = ST_ACQUIRE;
          end
        end
      end
      ST_ACQUIRE: begin
        if (tick) begin
          if (periods + 4'h1 >= acq_time) begin
            next_periods = '0;
            next_state   = ST_CONVERT;
          end else begin
            next_periods = periods + 4'h1;
          end
        end
      end
      ST_CONVERT: begin
        if (tick) begin
          next_bit_strobe = 1'b1;
          next_periods    = periods + 4'h1;
          if (finish) begin
            next_periods   = '0;
            next_conv_done = 1'b1;
            next_state     = ST_IDLE;
            if (start) begin
              next_state = (acq_time == '0) ? ST_CONVERT
                                            : ST_ACQUIRE;
            end
          end
        end
      end
      default: begin
        next_state   = ST_IDLE;
        next_periods = '0;
      end
    endcase
    next_sample     = (next_state != ST_CONVERT);
    next_converting = (next_state == ST_CONVERT);
  end

  always_ff @(posedge CLK_SYS) begin
    rc_meta <= RC_OSC;
    rc_sync <= rc_meta;
    if (RST) begin
      rc_last    <= 1'b0;
      wr_pending <= 1'b0;
      wr_addr    <= '0;
      HRDATA     <= 32'h00000000;
      HREADYOUT  <= 1'b1;
      HRESP      <= 1'b0;
      config_reg <= CONFIG_RESET;
      go         <= 1'b0;
      state      <= ST_IDLE;
      periods    <= '0;
      SAMPLE     <= 1'b1;
      CONVERTING <= 1'b0;
      BIT_STROBE <= 1'b0;
      CONV_DONE  <= 1'b0;
    end else begin
      rc_last    <= rc_sync;
      wr_pending <= next_wr_pending;
      wr_addr    <= next_wr_addr;
      HRDATA     <= next_hrdata;
      HREADYOUT  <= 1'b1;
      HRESP      <= 1'b0;
      config_reg <= next_config_reg;
      go         <= next_go;
      state      <= next_state;
      periods    <= next_periods;
      SAMPLE     <= next_sample;
      CONVERTING <= next_converting;
      BIT_STROBE <= next_bit_strobe;
      CONV_DONE  <= next_conv_done;
    end
  end

endmodule

// [common/adc_acq_pkg.sv]
package adc_acq_pkg;

  // register byte offsets
  localparam logic [7:0] CONFIG_OFFSET  = 8'h00;
  localparam logic [7:0] CONTROL_OFFSET = 8'h04;
  localparam int         ADDR_BITS      = 8;

  // acquisition_clock_config_reg fields
  localparam int ACQ_MSB = 6;
  localparam int ACQ_LSB = 3;
  localparam int CLK_MSB = 2;
  localparam int CLK_LSB = 0;
  localparam int ACQ_W   = ACQ_MSB - ACQ_LSB + 1;
  localparam int CLK_W   = CLK_MSB - CLK_LSB + 1;
  localparam int CFG_W   = ACQ_MSB + 1;
  localparam logic [CFG_W-1:0] CONFIG_RESET = 7'h00;

  // control register: go bit
  localparam int GO_BIT = 0;

  // conversion_clock_select encodings
  localparam logic [CLK_W-1:0] SEL_OSC2   = 3'h0;
  localparam logic [CLK_W-1:0] SEL_OSC4   = 3'h4;
  localparam logic [CLK_W-1:0] SEL_OSC8   = 3'h1;
  localparam logic [CLK_W-1:0] SEL_OSC16  = 3'h5;
  localparam logic [CLK_W-1:0] SEL_OSC32  = 3'h2;
  localparam logic [CLK_W-1:0] SEL_OSC64  = 3'h6;
  localparam logic [CLK_W-1:0] SEL_RC_DIV = 3'h3;
  localparam logic [CLK_W-1:0] SEL_RC     = 3'h7;

  localparam int DIV_W = 7;
  localparam logic [DIV_W-1:0] DIV_2  = 7'h02;
  localparam logic [DIV_W-1:0] DIV_4  = 7'h04;
  localparam logic [DIV_W-1:0] DIV_8  = 7'h08;
  localparam logic [DIV_W-1:0] DIV_16 = 7'h10;
  localparam logic [DIV_W-1:0] DIV_32 = 7'h20;
  localparam logic [DIV_W-1:0] DIV_64 = 7'h40;
  localparam logic [1:0] RC_DIV_LAST  = 2'h3;

  // twelve bit periods per ten-bit conversion
  localparam logic [3:0] CONV_PERIODS = 4'hc;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_ACQUIRE, ST_CONVERT} state_type;

endpackage

// [verilog/bit_period_gen.sv]
`timescale 1ns/100ps
module bit_period_gen
  import adc_acq_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             run,
  input  wire logic [CLK_W-1:0] select,
  input  wire logic             rc_rise,
  output logic                  tick
);

  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] next_count;
  logic [1:0]       rc_count;
  logic [1:0]       next_rc_count;
  logic [DIV_W-1:0] divisor;

  function automatic logic [DIV_W-1:0] osc_divisor(
    input logic [CLK_W-1:0] sel
  );
    case (sel)
      SEL_OSC2:  osc_divisor = DIV_2;
      SEL_OSC4:  osc_divisor = DIV_4;
      SEL_OSC8:  osc_divisor = DIV_8;
      SEL_OSC16: osc_divisor = DIV_16;
      SEL_OSC32: osc_divisor = DIV_32;
      default:   osc_divisor = DIV_64;
    endcase
  endfunction

  assign divisor = osc_divisor(select);

  // the divider restarts with every run so each bit period counted against divisor is whole;
  // tick is decoded from the count, not registered, so the first bit
  // period is not stretched by a cycle of latency
  always_comb begin
    next_count    = '0;
    next_rc_count = '0;
    tick          = 1'b0;
    if (run) begin
      next_count    = count;
      next_rc_count = rc_count;
      case (select)
        SEL_RC: begin
          tick = rc_rise;
        end
        SEL_RC_DIV: begin
          if (rc_rise) begin
            next_rc_count = rc_count + 2'h1;
            tick          = (rc_count == RC_DIV_LAST);
          end
        end
        default: begin
          if (count + 7'h01 >= divisor) begin
            next_count = '0;
            tick       = 1'b1;
          end else begin
            next_count = count + 7'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count    <= '0;
      rc_count <= '0;
    end else begin
      count    <= next_count;
      rc_count <= next_rc_count;
    end
  end

endmodule

// [tb/adc_acq_assertions.sv]
`timescale 1ns/100ps
module adc_acq_assertions
  import adc_acq_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        RST,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic        SAMPLE,
  input wire logic        CONVERTING,
  input wire logic        BIT_STROBE,
  input wire logic        CONV_DONE
);
  logic [3:0] strobes;
  logic [3:0] next_strobes;
  wire        rd = HSEL && HREADY && HTRANS == HTRANS_NONSEQ && !HWRITE;

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  // the done pulse rides on the last strobe, so eleven are already counted
  always_comb begin
    next_strobes = strobes;
    if (CONV_DONE)
      next_strobes = 4'h0;
    else if (BIT_STROBE && CONVERTING)
      next_strobes = strobes + 4'h1;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST)
      strobes <= 4'h0;
    else
      strobes <= next_strobes;
  end

  sequence s_conv_run;
    CONVERTING [*8];
  endsequence

  a_bus_okay: assert property (HREADYOUT && !HRESP)
    else $error("bus answer not ready okay");
  a_done_count: assert property (CONV_DONE |-> strobes == 4'hb)
    else $error("conversion not twelve bit periods");
  a_done_strobe: assert property (CONV_DONE |-> BIT_STROBE)
    else $error("done not on last bit period");
  a_conv_ends: assert property (
    $fell(CONVERTING) |-> CONV_DONE || $past(CONV_DONE))
    else $error("conversion ended without done");
  a_phase_excl: assert property (!(SAMPLE && CONVERTING))
    else $error("sampling during conversion");
  a_conv_min: assert property ($rose(CONVERTING) |-> s_conv_run)
    else $error("conversion too short");
  a_conv_max: assert property ($rose(CONVERTING) |-> ##[1:800] CONV_DONE)
    else $error("conversion never finished");
  a_strobe_pulse: assert property (BIT_STROBE |=> !BIT_STROBE)
    else $error("bit period below two cycles");
  a_cfg_width: assert property (
    rd && HADDR[7:0] == CONFIG_OFFSET |=> HRDATA[31:7] == 25'h0)
    else $error("config reads unused bits");
  a_unmapped_zero: assert property (
    rd && HADDR[7:0] > CONTROL_OFFSET |=> HRDATA == 32'h0)
    else $error("unmapped read not zero");
endmodule

bind adc_acq_ctrl adc_acq_assertions i_chk (.CLK_SYS, .RST, .HSEL, .HADDR,
  .HTRANS, .HWRITE, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .SAMPLE,
  .CONVERTING, .BIT_STROBE, .CONV_DONE);

// [tb/test_adc_acq_ctrl.sv]
`timescale 1ns/100ps
module test_adc_acq_ctrl
  import adc_acq_pkg::*;
;
  logic        clk_sys;
  logic        rst;
  logic        hsel;
  logic        hwrite;
  logic        rc_osc;
  logic        counting;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [1:0]  htrans;
  logic        hreadyout;
  logic        hresp;
  logic        sample;
  logic        converting;
  logic        bit_strobe;
  logic        conv_done;
  int          error_cnt;
  int          num_checks;
  int          conv_cyc;
  int          acq_cyc;
  int          strobes;
  int          exp_q [$];
  // zero marks the two RC sources, whose period is not a fixed cycle count
  int          div_tab [8] = '{2, 8, 32, 0, 4, 16, 64, 0};

  adc_acq_ctrl i_adc_acq_ctrl (
    .CLK_SYS(clk_sys), .RST(rst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hreadyout), .RC_OSC(rc_osc), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .SAMPLE(sample),
    .CONVERTING(converting), .BIT_STROBE(bit_strobe),
    .CONV_DONE(conv_done));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // odd offset keeps the RC edges off the system clock edges
  initial begin
    rc_osc = 1'b0;
    #3;
    forever #20 rc_osc = ~rc_osc;
  end

  always @(posedge clk_sys) begin
    if (counting && converting === 1'b1)
      conv_cyc <= conv_cyc + 1;
    if (counting && sample === 1'b1 && conv_cyc == 0)
      acq_cyc <= acq_cyc + 1;
    if (counting && conv_cyc != 0 && bit_strobe === 1'b1)
      strobes <= strobes + 1;
  end

  task check(input string what, input logic [31:0] exp,
             input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
    check("resp", 32'h0, {31'h0, hresp});
  endtask

  task run_conv(input logic [2:0] sel, input logic [3:0] n);
    logic [31:0] rd;
    int          k;
    conv_cyc = 0;
    acq_cyc = 0;
    strobes = 0;
    k = 0;
    // model: whole bit periods only, and no acquisition cycle at all
    // when the field is zero
    if (div_tab[sel] != 0) begin
      exp_q.push_back(12 * div_tab[sel]);
      exp_q.push_back(n * div_tab[sel]);
    end
    xfer(1'b1, CONFIG_OFFSET, {25'h0, n, sel}, rd);
    if (n == 4'h0) repeat (4) @(posedge clk_sys);
    xfer(1'b1, CONTROL_OFFSET, 32'h1, rd);
    counting <= 1'b1;
    xfer(1'b0, CONTROL_OFFSET, 32'h0, rd);
    check("go busy", 32'h1, rd);
    while (conv_done !== 1'b1 && k < 5000) begin
      @(posedge clk_sys);
      k++;
    end
    check("conv done", 32'h1, {31'h0, conv_done});
    counting <= 1'b0;
    @(posedge clk_sys);
    check("strobes", 12, strobes);
    if (div_tab[sel] != 0) begin
      check("conv cycles", exp_q.pop_front(), conv_cyc);
      check("acq cycles", exp_q.pop_front(), acq_cyc);
    end
    xfer(1'b0, CONTROL_OFFSET, 32'h0, rd);
    check("go done", 32'h0, rd);
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    #450000;
    error_cnt++;
    close_out;
  end

  initial begin
    logic [31:0] rd;
    logic [2:0]  sel;
    logic [3:0]  n;
    error_cnt = 0;
    num_checks = 0;
    counting = 1'b0;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    void'($urandom(32'hc1f84197));
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    xfer(1'b0, CONFIG_OFFSET, 32'h0, rd);
    check("config reset", 32'h0, rd);
    xfer(1'b0, CONTROL_OFFSET, 32'h0, rd);
    check("go reset", 32'h0, rd);
    xfer(1'b1, CONFIG_OFFSET, 32'hffffffff, rd);
    xfer(1'b0, CONFIG_OFFSET, 32'h0, rd);
    check("config", 32'h7f, rd);
    xfer(1'b1, 8'h08, $urandom, rd);
    xfer(1'b0, 8'h08, 32'h0, rd);
    check("unmapped", 32'h0, rd);
    $display("test registers done");
    // the bit-period floor and the sleep condition are analog limits;
    // a functional sweep of every source stands in for them
    for (int i = 0; i < 12; i++) begin
      sel = (i < 8) ? i[2:0] : 3'($urandom % 8);
      n = (i == 0) ? 4'h0 : 4'($urandom % 16);
      run_conv(sel, n);
      run_conv(sel, n);
    end
    $display("test conversions done");
    close_out;
  end
endmodule
